// ===== logic/lbx_expander.sv
// i2c slave, register file, blink generators and pin drivers
`timescale 1ns/10ps
// Summary of operation
// - start is sda falling while scl high
// - silent on the bus until a start
// - stop is sda rising while scl high
// - address upper nibble must equal 1100
// - receiver pulls sda low in ninth clock
// - ack own address and every written byte the fifo can take
// - read sends eight bits, then samples ack
// - master nack ends sending until stop
// - input registers show pin levels caught for each read byte
// - writes to input registers acked, ignored
// - low register pins 7..0, high 15..8
// - blink period (divider+1)/152 s, reset zero
// - blink duty is duty value over 256
// - auto increment steps write register address
// - auto increment steps read register address
// - pin levels caught at ack clock fall
// - reset holds registers and bus machine
// - each pin on, off, blink a, blink b
// - sda only pulled low or released

module lbx_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// fill side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// drain side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} lbx_fifo_s;
	lbx_fifo_s r;
	lbx_fifo_s next_r;
	logic push;
	logic pop;

	assign o_in_ready = (r.cnt != (AW+1)'(DEPTH));
	assign o_out_valid = (r.cnt != '0);
	assign o_out_data = r.mem[r.rp];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_comb begin
		next_r = r;
		if (push) begin
			next_r.mem[r.wp] = i_in_data;
			next_r.wp = (r.wp == AW'(DEPTH-1)) ? '0 : r.wp + 1'b1;
		end
		if (pop)
			next_r.rp = (r.rp == AW'(DEPTH-1)) ? '0 : r.rp + 1'b1;
		if (push && !pop)
			next_r.cnt = r.cnt + 1'b1;
		else if (pop && !push)
			next_r.cnt = r.cnt - 1'b1;
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			r.wp <= '0;
			r.rp <= '0;
			r.cnt <= '0;
			r.mem <= r.mem;
		end else begin
			r <= next_r;
		end
	end
endmodule

module lbx_expander
	import lbx_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// serial bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// address straps
	input wire logic i_addr_strap_bit0,
	input wire logic i_addr_strap_bit1,
	input wire logic i_addr_strap_bit2,
	// open-drain led / io pins
	input wire logic [15:0] i_driver_io_pins,
	output logic [15:0] o_driver_io_pins_out,
	output logic [15:0] o_driver_io_pins_oe
);
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [2:0] strap_s1;
		logic [2:0] strap_s2;
		logic [15:0] pin_s1;
		logic [15:0] pin_s2;
		logic scl_d;
		logic sda_d;
		lbx_state_e st;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic rw;
		logic got_cmd;
		logic auto_increment_flag;
		logic acked;
		logic [3:0] ptr;
		logic [7:0] pin_levels_low;
		logic [7:0] pin_levels_high;
		logic [7:0] blink_a_period_divider;
		logic [7:0] blink_a_duty_value;
		logic [7:0] blink_b_period_divider;
		logic [7:0] blink_b_duty_value;
		logic [31:0] sel;
		logic [11:0] tick_cnt;
		logic [7:0] pre_a;
		logic [7:0] pre_b;
		logic [7:0] ph_a;
		logic [7:0] ph_b;
		logic blink_rate_a;
		logic blink_rate_b;
		logic sda_oe;
		logic [15:0] pin_oe;
	} lbx_reg_s;

	lbx_reg_s r;
	lbx_reg_s next_r;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic addr_match;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [FIFO_WIDTH-1:0] fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [FIFO_WIDTH-1:0] fifo_out_data;
	logic tx_load;
	logic [15:0] pin_drive;

	function automatic logic [3:0] step_ptr(input logic [3:0] p);
		step_ptr = (p == IDX_LAST) ? 4'h0 : p + 4'h1;
	endfunction

	// read data; callers pass the state with this ack's pin capture in it
	function automatic logic [7:0] read_reg(input logic [3:0] idx,
		input lbx_reg_s s);
		case (idx)
			IDX_PIN_LO: read_reg = s.pin_levels_low;
			IDX_PIN_HI: read_reg = s.pin_levels_high;
			IDX_DIV_A: read_reg = s.blink_a_period_divider;
			IDX_DUTY_A: read_reg = s.blink_a_duty_value;
			IDX_DIV_B: read_reg = s.blink_b_period_divider;
			IDX_DUTY_B: read_reg = s.blink_b_duty_value;
			IDX_SEL0: read_reg = s.sel[7:0];
			IDX_SEL1: read_reg = s.sel[15:8];
			IDX_SEL2: read_reg = s.sel[23:16];
			IDX_SEL3: read_reg = s.sel[31:24];
			default: read_reg = 8'h00;
		endcase
	endfunction

	// edges seen only after the second synchroniser stage
	assign scl_rise = r.scl_s[1] && !r.scl_d;
	assign scl_fall = !r.scl_s[1] && r.scl_d;
	assign start_det = r.scl_s[1] && r.scl_d && !r.sda_s[1] && r.sda_d;
	assign stop_det = r.scl_s[1] && r.scl_d && r.sda_s[1] && !r.sda_d;
	assign addr_match = (r.shreg[7:4] == ADDR_PREFIX) &&
		(r.shreg[3:1] == r.strap_s2);

	// loading a read byte blocks the drain so reads see settled registers
	assign tx_load = scl_fall && ((r.st == ST_ACK && r.rw) ||
		(r.st == ST_ACK_TX && r.acked));
	assign fifo_out_ready = !tx_load;
	assign fifo_in_data = {r.ptr, r.shreg};
	assign fifo_in_valid = (r.st == ST_RX) && scl_fall &&
		(r.bitcnt == BITS_PER_BYTE) && r.got_cmd;

	lbx_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_in_valid(fifo_in_valid),
		.i_in_data(fifo_in_data),
		.o_in_ready(fifo_in_ready),
		.o_out_valid(fifo_out_valid),
		.o_out_data(fifo_out_data),
		.i_out_ready(fifo_out_ready)
	);

	// per-pin driver: low-side drive lights the led
	for (genvar g = 0; g < 16; g++) begin : g_pin
		always_comb begin
			unique case (r.sel[2*g +: 2])
				SEL_OFF: pin_drive[g] = 1'b0;
				SEL_ON: pin_drive[g] = 1'b1;
				SEL_BLINK_A: pin_drive[g] = r.blink_rate_a;
				SEL_BLINK_B: pin_drive[g] = r.blink_rate_b;
			endcase
		end
	end

	always_comb begin
		next_r = r;
		next_r.scl_s = {r.scl_s[0], i_scl};
		next_r.sda_s = {r.sda_s[0], i_sda};
		next_r.scl_d = r.scl_s[1];
		next_r.sda_d = r.sda_s[1];
		next_r.strap_s1 = {i_addr_strap_bit2, i_addr_strap_bit1,
			i_addr_strap_bit0};
		next_r.strap_s2 = r.strap_s1;
		next_r.pin_s1 = i_driver_io_pins;
		next_r.pin_s2 = r.pin_s1;
		next_r.pin_oe = pin_drive;

		// blink generators: one duty step every (divider+1) ticks
		if (r.tick_cnt == TICK_CYC - 12'h001) begin
			next_r.tick_cnt = 12'h000;
			if (r.pre_a == r.blink_a_period_divider) begin
				next_r.pre_a = 8'h00;
				next_r.ph_a = r.ph_a + 8'h01;
			end else begin
				next_r.pre_a = r.pre_a + 8'h01;
			end
			if (r.pre_b == r.blink_b_period_divider) begin
				next_r.pre_b = 8'h00;
				next_r.ph_b = r.ph_b + 8'h01;
			end else begin
				next_r.pre_b = r.pre_b + 8'h01;
			end
		end else begin
			next_r.tick_cnt = r.tick_cnt + 12'h001;
		end
		next_r.blink_rate_a = (r.ph_a < r.blink_a_duty_value);
		next_r.blink_rate_b = (r.ph_b < r.blink_b_duty_value);

		// register writes drained from the fifo
		if (fifo_out_valid && fifo_out_ready) begin
			case (fifo_out_data[11:8])
				IDX_DIV_A: next_r.blink_a_period_divider = fifo_out_data[7:0];
				IDX_DUTY_A: next_r.blink_a_duty_value = fifo_out_data[7:0];
				IDX_DIV_B: next_r.blink_b_period_divider = fifo_out_data[7:0];
				IDX_DUTY_B: next_r.blink_b_duty_value = fifo_out_data[7:0];
				IDX_SEL0: next_r.sel[7:0] = fifo_out_data[7:0];
				IDX_SEL1: next_r.sel[15:8] = fifo_out_data[7:0];
				IDX_SEL2: next_r.sel[23:16] = fifo_out_data[7:0];
				IDX_SEL3: next_r.sel[31:24] = fifo_out_data[7:0];
				default: ;
			endcase
		end

		// bus machine
		unique case (r.st)
			ST_IDLE: ;
			ST_ADDR, ST_RX: begin
				if (scl_rise && r.bitcnt != BITS_PER_BYTE) begin
					next_r.shreg = {r.shreg[6:0], r.sda_s[1]};
					next_r.bitcnt = r.bitcnt + 4'h1;
				end else if (scl_fall && r.bitcnt == BITS_PER_BYTE) begin
					next_r.bitcnt = 4'h0;
					if (r.st == ST_ADDR) begin
						if (addr_match) begin
							next_r.rw = r.shreg[0];
							next_r.sda_oe = 1'b1;
							next_r.st = ST_ACK;
						end else begin
							next_r.st = ST_IDLE;
						end
					end else if (!r.got_cmd) begin
						next_r.got_cmd = 1'b1;
						next_r.ptr = r.shreg[3:0];
						next_r.auto_increment_flag = r.shreg[CMD_AI_BIT];
						next_r.sda_oe = 1'b1;
						next_r.st = ST_ACK;
					end else if (fifo_in_ready) begin
						next_r.sda_oe = 1'b1;
						next_r.st = ST_ACK;
						if (r.auto_increment_flag)
							next_r.ptr = step_ptr(r.ptr);
					end else begin
						// full fifo: refuse the byte by leaving sda released
						next_r.st = ST_WAIT_STOP;
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					next_r.sda_oe = 1'b0;
					if (r.rw) begin
						// input levels caught at the ack clock fall
						next_r.pin_levels_low = r.pin_s2[7:0];
						next_r.pin_levels_high = r.pin_s2[15:8];
						next_r.shreg = read_reg(r.ptr, next_r);
						next_r.sda_oe = !next_r.shreg[7];
						next_r.st = ST_TX;
					end else begin
						next_r.st = ST_RX;
					end
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					if (r.bitcnt == BITS_PER_BYTE - 4'h1) begin
						next_r.bitcnt = 4'h0;
						next_r.sda_oe = 1'b0;
						next_r.st = ST_ACK_TX;
					end else begin
						next_r.bitcnt = r.bitcnt + 4'h1;
						next_r.shreg = {r.shreg[6:0], 1'b0};
						next_r.sda_oe = !r.shreg[6];
					end
				end
			end
			ST_ACK_TX: begin
				if (scl_rise)
					next_r.acked = !r.sda_s[1];
				else if (scl_fall) begin
					if (r.acked) begin
						next_r.pin_levels_low = r.pin_s2[7:0];
						next_r.pin_levels_high = r.pin_s2[15:8];
						next_r.ptr = r.auto_increment_flag ?
							step_ptr(r.ptr) : r.ptr;
						next_r.shreg = read_reg(next_r.ptr, next_r);
						next_r.sda_oe = !next_r.shreg[7];
						next_r.st = ST_TX;
					end else begin
						next_r.st = ST_WAIT_STOP;
					end
				end
			end
			ST_WAIT_STOP: ;
			default: next_r.st = ST_IDLE;
		endcase

		// bus conditions override the byte machine
		if (start_det) begin
			next_r.st = ST_ADDR;
			next_r.bitcnt = 4'h0;
			next_r.got_cmd = 1'b0;
			next_r.sda_oe = 1'b0;
		end else if (stop_det) begin
			next_r.st = ST_IDLE;
			next_r.sda_oe = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			r <= '0;
			r.scl_s <= 2'h3;
			r.sda_s <= 2'h3;
			r.scl_d <= 1'b1;
			r.sda_d <= 1'b1;
			r.st <= ST_IDLE;
			r.blink_a_period_divider <= RST_DIV;
			r.blink_b_period_divider <= RST_DIV;
			r.blink_a_duty_value <= RST_DUTY;
			r.blink_b_duty_value <= RST_DUTY;
			r.sel <= RST_SEL;
		end else begin
			r <= next_r;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = r.sda_oe;
	assign o_driver_io_pins_out = 16'h0000;
	assign o_driver_io_pins_oe = r.pin_oe;

	chk_sda_release_idle: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(r.st == ST_IDLE) |-> !o_sda_oe)
		else $error("sda driven while idle");

	chk_start_enters_addr: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		start_det |=> (r.st == ST_ADDR) && (r.bitcnt == 4'h0))
		else $error("start not taken");

	chk_stop_to_idle: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(stop_det && !start_det) |=> (r.st == ST_IDLE) && !o_sda_oe)
		else $error("stop not taken");

	chk_addr_ack_given: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(r.st == ST_ADDR && scl_fall && r.bitcnt == BITS_PER_BYTE &&
		addr_match && !start_det && !stop_det)
		|=> (r.st == ST_ACK) && o_sda_oe)
		else $error("own address not acknowledged");

	chk_addr_mismatch_quiet: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(r.st == ST_ADDR && scl_fall && r.bitcnt == BITS_PER_BYTE &&
		r.shreg[7:4] != ADDR_PREFIX && !start_det)
		|=> (r.st == ST_IDLE) && !o_sda_oe)
		else $error("foreign address acknowledged");

	chk_nack_waits_stop: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(r.st == ST_ACK_TX && scl_fall && !r.acked && !start_det &&
		!stop_det) |=> (r.st == ST_WAIT_STOP) ##1 !o_sda_oe)
		else $error("sending went on after nack");

	chk_sda_never_high: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		o_sda_oe |-> (o_sda_out == 1'b0))
		else $error("sda driven high");

	chk_pin_off_released: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(r.sel[1:0] == SEL_OFF) ##1 (r.sel[1:0] == SEL_OFF)
		|-> !o_driver_io_pins_oe[0])
		else $error("off pin still driven");

	chk_zero_duty_dark: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(r.blink_a_duty_value == 8'h00) ##1
		(r.blink_a_duty_value == 8'h00) |-> !r.blink_rate_a)
		else $error("blink on with zero duty");

	chk_ro_regs_unwritten: assert property (
		@(posedge i_clk) disable iff (!i_nrst)
		(fifo_out_valid && fifo_out_ready &&
		fifo_out_data[11:8] <= IDX_PIN_HI && !tx_load)
		|=> $stable(r.pin_levels_low) && $stable(r.pin_levels_high))
		else $error("input register altered by write");
endmodule

// ===== logic/lbx_pkg.sv
// constants and types for the blinking led driver and i/o expander
package lbx_pkg;
	// bus address: fixed upper nibble, then three strap bits, then r/w
	localparam logic [3:0] ADDR_PREFIX = 4'hC;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// register indices reached through the register pointer
	localparam logic [3:0] IDX_PIN_LO = 4'h0;
	localparam logic [3:0] IDX_PIN_HI = 4'h1;
	localparam logic [3:0] IDX_DIV_A = 4'h2;
	localparam logic [3:0] IDX_DUTY_A = 4'h3;
	localparam logic [3:0] IDX_DIV_B = 4'h4;
	localparam logic [3:0] IDX_DUTY_B = 4'h5;
	localparam logic [3:0] IDX_SEL0 = 4'h6;
	localparam logic [3:0] IDX_SEL1 = 4'h7;
	localparam logic [3:0] IDX_SEL2 = 4'h8;
	localparam logic [3:0] IDX_SEL3 = 4'h9;
	localparam logic [3:0] IDX_LAST = 4'h9;
	// command byte layout
	localparam int CMD_AI_BIT = 4;
	// values after reset
	localparam logic [7:0] RST_DIV = 8'h00;
	localparam logic [7:0] RST_DUTY = 8'h00;
	localparam logic [31:0] RST_SEL = 32'h0000_0000;
	// pin selector codes
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_ON = 2'h1;
	localparam logic [1:0] SEL_BLINK_A = 2'h2;
	localparam logic [1:0] SEL_BLINK_B = 2'h3;
	// blink timing: period = (divider + 1) / 152 s, 256 duty steps
	localparam int CLK_HZ = 100_000_000;
	localparam int BLINK_BASE_HZ = 152;
	localparam int DUTY_STEPS = 256;
	localparam int TICK_CYC_I = CLK_HZ / (BLINK_BASE_HZ * DUTY_STEPS);
	localparam logic [11:0] TICK_CYC = 12'(TICK_CYC_I);
	// write fifo
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 12;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b010,
		ST_RX = 3'b011,
		ST_TX = 3'b100,
		ST_ACK_TX = 3'b101,
		ST_WAIT_STOP = 3'b110
	} lbx_state_e;
endpackage

// ===== testbench/lbx_i2c_master.sv
// behavioural serial bus master driving scl and pulling sda
`timescale 1ns/10ps
module lbx_i2c_master (
	// clock
	input wire logic i_clk,
	// serial bus
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_oe
);
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end

	// data moves a clock after scl falls so it never races the fall
	task automatic bit_io(input logic b, output logic r);
		@(posedge i_clk);
		o_sda_oe <= ~b;
		repeat (4) @(posedge i_clk);
		o_scl <= 1'b1;
		repeat (3) @(posedge i_clk);
		r = i_sda;
		o_scl <= 1'b0;
	endtask

	// also serves as repeated start; issued after a stop or straight after a byte
	task automatic start();
		@(posedge i_clk);
		o_sda_oe <= 1'b0;
		repeat (4) @(posedge i_clk);
		o_scl <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_sda_oe <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_scl <= 1'b0;
	endtask

	task automatic stop();
		@(posedge i_clk);
		o_sda_oe <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_scl <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_sda_oe <= 1'b0;
		repeat (4) @(posedge i_clk);
	endtask

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	task automatic rd_byte(input logic ack_send, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~ack_send, r);
	endtask
endmodule

// ===== testbench/tb_lbx_expander.sv
// self-checking bench for the led driver and i/o expander
`timescale 1ns/10ps
module tb_lbx_expander;
	import lbx_pkg::*;
	logic clk;
	logic nrst;
	logic [2:0] strap;
	logic [15:0] ext_low;
	logic scl;
	logic m_sda_oe;
	logic sda_out;
	logic sda_oe;
	logic sda;
	logic [15:0] pins_out;
	logic [15:0] pins_oe;
	logic [15:0] pins;
	logic [7:0] got_byte;
	int errors;
	int num_checks;

	// pull-ups: a line is low only while some party pulls it
	assign sda = ~(m_sda_oe | sda_oe);
	assign pins = ~(pins_oe | ext_low);

	lbx_i2c_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl),
		.o_sda_oe(m_sda_oe));

	lbx_expander uut (.i_clk(clk), .i_nrst(nrst), .i_scl(scl),
		.i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.i_addr_strap_bit0(strap[0]), .i_addr_strap_bit1(strap[1]),
		.i_addr_strap_bit2(strap[2]), .i_driver_io_pins(pins),
		.o_driver_io_pins_out(pins_out), .o_driver_io_pins_oe(pins_oe));

	always #5 clk = ~clk;

	task automatic end_of_test();
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic send(input logic [7:0] d, input logic e, input string s);
		logic a;
		m.wr_byte(d, a);
		chk(s, {15'h0, e}, {15'h0, a});
	endtask

	task automatic reg_write(input logic [3:0] p, input logic ai,
		input logic [7:0] d[$]);
		m.start();
		send({ADDR_PREFIX, strap, 1'b0}, 1'b1, "write addr ack");
		send({3'h0, ai, p}, 1'b1, "command ack");
		foreach (d[i])
			send(d[i], 1'b1, "data ack");
		m.stop();
	endtask

	// the last byte is not acknowledged so the stop finds sda released
	task automatic reg_read(input logic [3:0] p, input logic [7:0] e[$]);
		m.start();
		send({ADDR_PREFIX, strap, 1'b0}, 1'b1, "write addr ack");
		send({3'h0, 1'b1, p}, 1'b1, "command ack");
		m.start();
		send({ADDR_PREFIX, strap, 1'b1}, 1'b1, "read addr ack");
		foreach (e[i]) begin
			m.rd_byte(i < e.size() - 1, got_byte);
			chk("read byte", {8'h00, e[i]}, {8'h00, got_byte});
		end
		m.stop();
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		end_of_test();
	end

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		strap = 3'h5;
		ext_low = 16'h0000;
		errors = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		chk("sda oe at reset", 16'h0000, {15'h0, sda_oe});
		chk("pin oe at reset", 16'h0000, pins_oe);
		// a byte clocked in without any start must stay unanswered
		send({ADDR_PREFIX, strap, 1'b0}, 1'b0, "ack without start");
		m.stop();
		m.start();
		send({4'hD, strap, 1'b0}, 1'b0, "foreign prefix");
		m.stop();
		m.start();
		send({ADDR_PREFIX, 3'h4, 1'b0}, 1'b0, "foreign strap");
		m.stop();
		reg_read(IDX_DIV_A, '{8'h00, 8'h00, 8'h00, 8'h00});
		reg_write(IDX_DIV_A, 1'b1, '{8'hA1, 8'h00, 8'hC3, 8'h00});
		reg_read(IDX_DIV_A, '{8'hA1, 8'h00, 8'hC3, 8'h00});
		reg_write(IDX_DIV_A, 1'b0, '{8'h11, 8'h22});
		reg_read(IDX_DIV_A, '{8'h22, 8'h00, 8'hC3});
		ext_low <= 16'h4400;
		reg_write(IDX_SEL0, 1'b1, '{8'h55, 8'h00, 8'h05, 8'hE0});
		// zero duty keeps both blinking pins released
		chk("pin drive", 16'h030F, pins_oe);
		chk("sda drive level", 16'h0000, {15'h0, sda_out});
		chk("pin drive level", 16'h0000, pins_out);
		reg_write(IDX_PIN_LO, 1'b1, '{8'h55, 8'hAA});
		chk("pin drive kept", 16'h030F, pins_oe);
		reg_read(IDX_SEL3, '{8'hE0, 8'hF0, 8'hB8, 8'h22});
		m.start();
		send({ADDR_PREFIX, strap, 1'b1}, 1'b1, "read addr ack");
		m.rd_byte(1'b0, got_byte);
		m.rd_byte(1'b0, got_byte);
		chk("silent after nack", 16'h00FF, {8'h00, got_byte});
		m.stop();
		// long burst through the write queue: wraps past the last index,
		// steps over the read-only pair, then rewrites the first two
		reg_write(IDX_DIV_A, 1'b1, '{8'h01, 8'h80, 8'h02, 8'h00, 8'h55,
			8'h00, 8'h05, 8'hE0, 8'h77, 8'h66, 8'h33, 8'h80});
		reg_read(IDX_DIV_A, '{8'h33, 8'h80, 8'h02, 8'h00, 8'h55});
		// half duty on blink a lights pin 14 while the phase is still low
		chk("blink pin drive", 16'h430F, pins_oe);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		chk("pin oe after reset", 16'h0000, pins_oe);
		reg_read(IDX_DIV_A, '{8'h00, 8'h00, 8'h00});
		end_of_test();
	end
endmodule
